// ---- core/asm_slot_mapper.sv ----
// Purpose: maps two audio channels onto serial lines and slots, apb registers
// Assumes: pins synchronous to pclk, pclk 50 MHz
// Notes:   bit clock shifts data out on its falling edge
// Operation
// RULE1: channel one line bit picks output
// RULE2: channel two line bit picks output
// RULE3: index 0-31 is tdm or left slot
// RULE4: index 32-63 is tdm or right slot
// RULE5: channel one config resets to zero
// RULE6: channel two config resets to one
// RULE7: bit seven reads zero, keep zero
// RULE8: master config resets to 0x02
// RULE9: master bit decides who drives clocks
// RULE10: auto bit selects derived or custom dividers
// RULE11: gate bit stops master bit clock, sync
// RULE12: reference field encodes input clock frequency
// RULE13: sample sent only on chosen line, slot
`timescale 1ns/1ps
`default_nettype none
`include "asm_defines.svh"
module asm_slot_mapper #(
   parameter int WORD_BITS  = 32,
   parameter int FRAME_BITS = 256
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [WORD_BITS-1:0] chan_one_sample,
   input  wire logic [WORD_BITS-1:0] chan_two_sample,
   input  wire logic                 bclk_in,
   output logic                      bclk_out,
   output logic                      bclk_oe,
   input  wire logic                 frame_sync_in,
   output logic                      frame_sync_out,
   output logic                      frame_sync_oe,
   output logic                      primary_serial_out,
   output logic                      secondary_serial_out,
   output logic                      pll_enable,
   output logic      [15:0]          ref_clock_khz
);
   initial begin
      if (WORD_BITS < 8 || WORD_BITS > 32 || FRAME_BITS < 2 * WORD_BITS || FRAME_BITS > 4095)
         $error("asm_slot_mapper: unsupported WORD_BITS or FRAME_BITS");
   end

   // ==========================================================
   // helpers
   function automatic logic [11:0] slot_start(input logic [5:0] idx, input logic half_fmt);
      logic [11:0] s;
      s = 12'h000;
      if (half_fmt && idx[5])
         s = 12'((FRAME_BITS / 2) + idx[4:0] * WORD_BITS);
      else
         s = 12'(idx * WORD_BITS);
      return s;
   endfunction : slot_start

   function automatic logic slot_bit(input logic [11:0] cnt, input logic [11:0] start,
                                     input logic [WORD_BITS-1:0] smp);
      logic [11:0] off;
      off = cnt - start;
      if (cnt >= start && off < 12'(WORD_BITS))
         return smp[WORD_BITS-1-off];
      return 1'b0;
   endfunction : slot_bit

   // ==========================================================
   // apb registers
   logic [7:0]  ch1_q, ch2_q, mst_q, fmt_q;
   logic        wr_en;
   logic [5:0]  idx;
   logic        mapped;
   assign idx    = paddr[7:2];
   assign wr_en  = psel && penable && pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (idx == `ASM_IDX_CH1 || idx == `ASM_IDX_CH2 ||
                   idx == `ASM_IDX_MST || idx == `ASM_IDX_FMT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ch1_q <= `ASM_RST_CH1; // RULE5
         ch2_q <= `ASM_RST_CH2; // RULE6
         mst_q <= `ASM_RST_MST; // RULE8
         fmt_q <= `ASM_RST_FMT;
      end else if (wr_en && mapped) begin
         // top bit of the channel registers is not stored
         if (idx == `ASM_IDX_CH1) ch1_q <= {1'b0, pwdata[6:0]}; // RULE7
         if (idx == `ASM_IDX_CH2) ch2_q <= {1'b0, pwdata[6:0]}; // RULE7
         if (idx == `ASM_IDX_MST) mst_q <= pwdata[7:0];
         if (idx == `ASM_IDX_FMT) fmt_q <= {7'h00, pwdata[0]};
      end
   end

   // read data is prepared in the setup phase so the slave needs no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= !mapped;
            prdata  <= 32'h00000000;
            if (!pwrite && mapped) begin
               case (idx)
                  `ASM_IDX_CH1: prdata <= {24'h000000, ch1_q};
                  `ASM_IDX_CH2: prdata <= {24'h000000, ch2_q};
                  `ASM_IDX_MST: prdata <= {24'h000000, mst_q};
                  default:      prdata <= {24'h000000, fmt_q};
               endcase
            end
         end
      end
   end

   // ==========================================================
   // clocking configuration
   asm_pkg::asm_role_t role;
   logic               gate;
   logic [7:0]         half_cnt;
   logic [7:0]         div_q;
   assign role     = asm_pkg::asm_role_t'(mst_q[`ASM_MS_BIT]);
   assign gate     = mst_q[`ASM_GATE_BIT];
   assign half_cnt = mst_q[`ASM_AUTO_BIT] ? 8'(`ASM_BCLK_HALF_CUSTOM) // RULE10
                                          : 8'(`ASM_BCLK_HALF_AUTO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_enable    <= 1'b0;
         ref_clock_khz <= 16'h0000;
      end else begin
         // pll only runs under automatic derivation
         pll_enable <= !mst_q[`ASM_AUTO_BIT] && !mst_q[`ASM_PLLDIS_BIT]; // RULE10
         case (mst_q[2:0]) // RULE12
            3'h0:    ref_clock_khz <= 16'h2EE0;
            3'h1:    ref_clock_khz <= 16'h3000;
            3'h2:    ref_clock_khz <= 16'h32C8;
            3'h3:    ref_clock_khz <= 16'h3E80;
            3'h4:    ref_clock_khz <= 16'h4B00;
            3'h5:    ref_clock_khz <= 16'h4CE0;
            3'h6:    ref_clock_khz <= 16'h5DC0;
            default: ref_clock_khz <= 16'h6000;
         endcase
      end
   end

   // ==========================================================
   // bit clock and frame sync
   asm_pkg::asm_state_t state;
   logic        bclk_prev_q;
   logic        tick;
   logic        fstart;
   logic [11:0] cnt_q, cnt_d;
   assign state = (role == asm_pkg::ASM_MASTER && gate) ? asm_pkg::ASM_ST_HOLD
                                                        : asm_pkg::ASM_ST_RUN; // RULE11

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q         <= 8'h00;
         bclk_out      <= 1'b0;
         bclk_oe       <= 1'b0;
         frame_sync_oe <= 1'b0;
         bclk_prev_q   <= 1'b0;
      end else begin
         bclk_oe       <= (role == asm_pkg::ASM_MASTER); // RULE9
         frame_sync_oe <= (role == asm_pkg::ASM_MASTER); // RULE9
         bclk_prev_q   <= bclk_in;
         case (state)
            asm_pkg::ASM_ST_HOLD: begin
               div_q    <= 8'h00;
               bclk_out <= 1'b0; // RULE11
            end
            default: begin
               if (div_q >= half_cnt - 8'h01) begin
                  div_q    <= 8'h00;
                  bclk_out <= !bclk_out;
               end else begin
                  div_q <= div_q + 8'h01;
               end
            end
         endcase
      end
   end

   // falling edge of whichever clock owns the link
   always_comb begin
      tick   = 1'b0;
      fstart = 1'b0;
      if (role == asm_pkg::ASM_MASTER) begin
         tick   = (state == asm_pkg::ASM_ST_RUN) && bclk_out && (div_q >= half_cnt - 8'h01);
         fstart = (cnt_q == 12'(FRAME_BITS - 1));
      end else begin
         tick   = bclk_prev_q && !bclk_in;
         fstart = frame_sync_in;
      end
      cnt_d = fstart ? 12'h000 : cnt_q + 12'h001;
   end

   // ==========================================================
   // slot placement
   logic [WORD_BITS-1:0] smp1_q, smp2_q, smp1_now, smp2_now;
   logic [11:0]          st1, st2;
   logic                 b1, b2;
   assign smp1_now = fstart ? chan_one_sample : smp1_q;
   assign smp2_now = fstart ? chan_two_sample : smp2_q;
   assign st1 = slot_start(ch1_q[5:0], fmt_q[0]); // RULE3 RULE4
   assign st2 = slot_start(ch2_q[5:0], fmt_q[0]); // RULE3 RULE4
   assign b1  = slot_bit(cnt_d, st1, smp1_now);   // RULE13
   assign b2  = slot_bit(cnt_d, st2, smp2_now);   // RULE13

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q                <= 12'h000;
         smp1_q               <= '0;
         smp2_q               <= '0;
         frame_sync_out       <= 1'b0;
         primary_serial_out   <= 1'b0;
         secondary_serial_out <= 1'b0;
      end else if (state == asm_pkg::ASM_ST_HOLD) begin
         frame_sync_out <= 1'b0; // RULE11
      end else if (tick) begin
         cnt_q          <= cnt_d;
         smp1_q         <= smp1_now;
         smp2_q         <= smp2_now;
         frame_sync_out <= (cnt_d == 12'h000);
         // two channels on one line overlap only when software assigns the same slot
         primary_serial_out   <= (!ch1_q[`ASM_LINE_BIT] && b1) || // RULE1
                                 (!ch2_q[`ASM_LINE_BIT] && b2);   // RULE2
         secondary_serial_out <= (ch1_q[`ASM_LINE_BIT] && b1) ||  // RULE1
                                 (ch2_q[`ASM_LINE_BIT] && b2);    // RULE2
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ch1_reset: assert property (!$past(presetn) |-> ch1_q == 8'h00) // RULE5
      else $error("channel one config not zero after reset");
   chk_ch2_reset: assert property (!$past(presetn) |-> ch2_q == 8'h01) // RULE6
      else $error("channel two config not one after reset");
   chk_mst_reset: assert property (!$past(presetn) |-> mst_q == 8'h02) // RULE8
      else $error("master config not 0x02 after reset");
   chk_top_bit_zero: assert property ( // RULE7
      psel && penable && !pwrite && (idx == `ASM_IDX_CH1 || idx == `ASM_IDX_CH2)
      |-> prdata[7] == 1'b0)
      else $error("reserved channel bit read as one");
   // lines only change at a bit clock edge, so the check waits for one
   chk_sec_line_idle: assert property ( // RULE1
      tick && !ch1_q[`ASM_LINE_BIT] && !ch2_q[`ASM_LINE_BIT] |=> !secondary_serial_out)
      else $error("secondary line driven with both channels on primary");
   chk_pri_line_idle: assert property ( // RULE2
      tick && ch1_q[`ASM_LINE_BIT] && ch2_q[`ASM_LINE_BIT] |=> !primary_serial_out)
      else $error("primary line driven with both channels on secondary");
   chk_low_slot_msb: assert property ( // RULE3
      tick && !ch1_q[6] && ch2_q[6] && !ch1_q[5] && cnt_d == 12'(ch1_q[4:0] * WORD_BITS)
      |=> primary_serial_out == $past(smp1_now[WORD_BITS-1]))
      else $error("channel one msb not at its low slot");
   chk_high_slot_msb: assert property ( // RULE4
      tick && fmt_q[0] && !ch1_q[6] && ch2_q[6] && ch1_q[5]
      && cnt_d == 12'(FRAME_BITS / 2 + ch1_q[4:0] * WORD_BITS)
      |=> primary_serial_out == $past(smp1_now[WORD_BITS-1]))
      else $error("channel one msb not at its right slot");
   chk_role_drive: assert property ( // RULE9
      $stable(mst_q[7])[*2] |-> bclk_oe == mst_q[7] && frame_sync_oe == mst_q[7])
      else $error("clock pin drive does not follow role");
   chk_gate_hold: assert property (mst_q[7] && mst_q[4] |=> !bclk_out && !frame_sync_out) // RULE11
      else $error("gated master clocks still toggling");
   // outputs lag the register by one cycle, so compare against last cycle's bits
   chk_pll_auto: assert property ( // RULE10
      $past(presetn) && $stable(mst_q)
      |=> pll_enable == (!$past(mst_q[`ASM_AUTO_BIT]) && !$past(mst_q[`ASM_PLLDIS_BIT])))
      else $error("pll enable does not follow auto bit");
   chk_ref_13m: assert property ( // RULE12
      $past(presetn) && mst_q[2:0] == 3'h2 |=> ref_clock_khz == 16'h32C8)
      else $error("reference code 2 not 13 MHz");

   cov_master_frame: cover property (role == asm_pkg::ASM_MASTER && tick && fstart);
   cov_slave_frame:  cover property (role == asm_pkg::ASM_SLAVE && tick && frame_sync_in);
   cov_right_slot:   cover property (tick && fmt_q[0] && ch2_q[5] && cnt_d == st2);
endmodule : asm_slot_mapper
`default_nettype wire

// ---- core/asm_defines.svh ----
// Purpose: constants of the channel slot mapper
// Assumes: apb byte address is four times the register index
// Notes:   definitions only
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH
`define ASM_IDX_CH1      6'h0B
`define ASM_IDX_CH2      6'h0C
`define ASM_IDX_MST      6'h13
`define ASM_IDX_FMT      6'h1F
`define ASM_RST_CH1      8'h00
`define ASM_RST_CH2      8'h01
`define ASM_RST_MST      8'h02
`define ASM_RST_FMT      8'h00
`define ASM_LINE_BIT     6
`define ASM_MS_BIT       7
`define ASM_AUTO_BIT     6
`define ASM_PLLDIS_BIT   5
`define ASM_GATE_BIT     4
`define ASM_FSMODE_BIT   3
`define ASM_BCLK_HALF_AUTO   4
`define ASM_BCLK_HALF_CUSTOM 8
`endif

// ---- core/asm_pkg.sv ----
// Purpose: types of the channel slot mapper
// Assumes: nothing
// Notes:   none
package asm_pkg;
   typedef enum logic {ASM_SLAVE = 1'b0, ASM_MASTER = 1'b1} asm_role_t;
   typedef enum logic {ASM_ST_HOLD = 1'b0, ASM_ST_RUN = 1'b1} asm_state_t;
endpackage : asm_pkg

// ---- testbench/asm_host_model.sv ----
// Purpose: host serial port receiving frames from the slot mapper
// Assumes: host makes bit clock and frame sync while the mapper is slave
// Notes:   frame bit n is kept at position FRAME_BITS-1-n
`timescale 1ns/1ps
`default_nettype none
module asm_host_model #(
   parameter int FRAME_BITS = 128,
   parameter int HALF       = 5
) (
   input  wire logic                  pclk,
   input  wire logic                  dev_master,
   input  wire logic                  bclk,
   input  wire logic                  frame_sync,
   input  wire logic                  prim,
   input  wire logic                  sec,
   output logic                       bclk_drv,
   output logic                       frame_sync_drv,
   output logic      [FRAME_BITS-1:0] prim_frame,
   output logic      [FRAME_BITS-1:0] sec_frame,
   output logic      [31:0]           frame_cnt
);
   logic [FRAME_BITS-1:0] prim_sh = '0;
   logic [FRAME_BITS-1:0] sec_sh  = '0;
   logic                  bclk_q  = 1'b0;
   logic [7:0]            hdiv_q  = 8'h00;
   logic [11:0]           hbit_q  = 12'h000;
   logic                  rise;
   logic                  fs;
   // host clock runs free while the mapper is slave and rests low while it masters
   assign rise = dev_master ? (bclk && !bclk_q) : (hdiv_q == 8'(HALF - 1) && !bclk_drv);
   assign fs   = dev_master ? frame_sync : frame_sync_drv;
   initial begin
      frame_cnt = '0;
      bclk_drv  = 1'b0;
      frame_sync_drv = 1'b0;
   end
   always @(posedge pclk) begin
      bclk_q <= bclk;
      if (dev_master) begin
         hdiv_q    <= 8'h00;
         hbit_q    <= 12'(FRAME_BITS - 1);
         bclk_drv  <= 1'b0;
         frame_sync_drv <= 1'b0;
      end else if (hdiv_q == 8'(HALF - 1)) begin
         hdiv_q   <= 8'h00;
         bclk_drv <= !bclk_drv;
         // next bit and frame sync change on the falling edge
         if (bclk_drv) begin
            hbit_q    <= (hbit_q == 12'(FRAME_BITS - 1)) ? 12'h000 : hbit_q + 12'h001;
            frame_sync_drv <= (hbit_q == 12'(FRAME_BITS - 1));
         end
      end else begin
         hdiv_q <= hdiv_q + 8'h01;
      end
      if (rise) begin
         if (fs) begin
            prim_frame <= prim_sh;
            sec_frame  <= sec_sh;
            frame_cnt  <= frame_cnt + 1;
            prim_sh    <= {{(FRAME_BITS-1){1'b0}}, prim};
            sec_sh     <= {{(FRAME_BITS-1){1'b0}}, sec};
         end else begin
            prim_sh <= {prim_sh[FRAME_BITS-2:0], prim};
            sec_sh  <= {sec_sh[FRAME_BITS-2:0], sec};
         end
      end
   end
endmodule : asm_host_model
`default_nettype wire

// ---- testbench/asm_slot_mapper_bench.sv ----
// Purpose: self-checking bench of the channel slot mapper
// Assumes: zero-wait apb slave, 16-bit words, 128-bit frames
// Notes:   first frame after a change is partial, so waits skip it
`timescale 1ns/1ps
`default_nettype none
module asm_slot_mapper_bench;
   localparam int FB = 128;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, frame_cnt;
   logic pready, pslverr, er, bclk_in, bclk_out, bclk_oe, fs_in, fs_out, fs_oe;
   logic prim, sec, pll_enable;
   logic [15:0] ch1 = 16'hA5C3, ch2 = 16'h3C5A, ref_clock_khz;
   logic [FB-1:0] pf, sf;
   int err_total = 0, checked = 0, cyc = 0;
   const int khz[8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
   always #10 pclk = ~pclk;
   asm_slot_mapper #(.WORD_BITS(16), .FRAME_BITS(FB)) asm_slot_mapper_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_one_sample(ch1), .chan_two_sample(ch2), .bclk_in(bclk_in), .bclk_out(bclk_out),
      .bclk_oe(bclk_oe), .frame_sync_in(fs_in), .frame_sync_out(fs_out),
      .frame_sync_oe(fs_oe), .primary_serial_out(prim), .secondary_serial_out(sec),
      .pll_enable(pll_enable), .ref_clock_khz(ref_clock_khz));
   asm_host_model #(.FRAME_BITS(FB)) asm_host_model_i (
      .pclk(pclk), .dev_master(bclk_oe), .bclk(bclk_out), .frame_sync(fs_out), .prim(prim), .sec(sec),
      .bclk_drv(bclk_in), .frame_sync_drv(fs_in), .prim_frame(pf), .sec_frame(sf),
      .frame_cnt(frame_cnt));
   // ==========================================
   // bus and compare tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_frame(input logic [FB-1:0] got, input logic [FB-1:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: frame %h, expected %h", $time, got, exp);
      end
   endtask : chk_frame
   function automatic logic [FB-1:0] place(input logic [15:0] s, input int pos);
      place = '0;
      place[FB-1-pos -: 16] = s;
   endfunction : place
   task automatic frames(input int n);
      int base;
      base = frame_cnt;
      while (frame_cnt < base + n) @(posedge pclk);
   endtask : frames
   // ==========================================
   // scenarios
   task automatic t_reset;
      chk(bclk_oe, 0);
      apb(0, 8'h2C, 0); chk(rd, 32'h00);
      apb(0, 8'h30, 0); chk(rd, 32'h01);
      apb(0, 8'h4C, 0); chk(rd, 32'h02);
      apb(0, 8'h80, 0); chk(er, 1);
      apb(1, 8'h2C, 32'h7F); apb(0, 8'h2C, 0); chk(rd, 32'h7F);
      apb(1, 8'h2C, 32'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_master;
      for (int i = 0; i < 8; i++) begin
         apb(1, 8'h4C, 32'h80 | i); apb(0, 8'h4C, 0);
         chk(ref_clock_khz, khz[i]);
      end
      apb(1, 8'h4C, 32'hC2); apb(0, 8'h4C, 0); chk(pll_enable, 0);
      apb(1, 8'h4C, 32'h82); apb(0, 8'h4C, 0); chk(pll_enable, 1);
      chk(bclk_oe, 1);
      chk(fs_oe, 1);
      $display("master test done");
   endtask : t_master
   task automatic t_tdm;
      frames(3);
      chk_frame(pf, place(ch1, 0) | place(ch2, 16));
      chk_frame(sf, '0);
      $display("tdm test done");
   endtask : t_tdm
   task automatic t_lines;
      apb(1, 8'h7C, 32'h01);
      apb(1, 8'h2C, 32'h61);
      apb(1, 8'h30, 32'h02);
      frames(3);
      chk_frame(sf, place(ch1, FB/2 + 16));
      chk_frame(pf, place(ch2, 32));
      apb(1, 8'h2C, 32'h20);
      apb(1, 8'h30, 32'h42);
      frames(3);
      chk_frame(pf, place(ch1, FB/2));
      chk_frame(sf, place(ch2, 32));
      $display("line test done");
   endtask : t_lines
   task automatic t_slave;
      apb(1, 8'h4C, 32'h02);
      apb(1, 8'h2C, 32'h05);
      frames(3);
      chk(bclk_oe | fs_oe, 0);
      chk_frame(pf, place(ch1, 80));
      chk_frame(sf, place(ch2, 32));
      apb(1, 8'h2C, 32'h61);
      frames(3);
      chk_frame(sf, place(ch1, FB/2 + 16) | place(ch2, 32));
      chk_frame(pf, '0);
      $display("slave test done");
   endtask : t_slave
   task automatic t_gate;
      apb(1, 8'h4C, 32'h92);
      repeat (20) @(posedge pclk);
      for (int i = 0; i < 40; i++) begin
         @(posedge pclk);
         chk(bclk_out | fs_out, 0);
      end
      $display("gate test done");
   endtask : t_gate
   // ==========================================
   // run control
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_master();
      t_tdm();
      t_lines();
      t_gate();
      t_slave();
      end_sim();
   end
endmodule : asm_slot_mapper_bench
`default_nettype wire
